// file: flash_spm_pkg.sv
// Constants and types for the flash self-programming read-while-write control
package flash_spm_pkg;

  localparam int ADDR_W    = 15;
  localparam int PAGE_BITS = 7;
  localparam int PAGE_W    = ADDR_W - PAGE_BITS;

  // Fixed split: the halting section starts here, the concurrent read section lies below
  localparam logic [ADDR_W-1:0] HALT_SECTION_START = 15'h7000;

  // Boot loader start per boot_size_fuses code; all lie inside the halting section
  localparam logic [ADDR_W-1:0] BOOT_START_SZ0 = 15'h7000;
  localparam logic [ADDR_W-1:0] BOOT_START_SZ1 = 15'h7800;
  localparam logic [ADDR_W-1:0] BOOT_START_SZ2 = 15'h7c00;
  localparam logic [ADDR_W-1:0] BOOT_START_SZ3 = 15'h7e00;

  localparam logic [1:0] FUSE_SZ0 = 2'h0;
  localparam logic [1:0] FUSE_SZ1 = 2'h1;
  localparam logic [1:0] FUSE_SZ2 = 2'h2;

  // Lock bits: 1 is unprogrammed, 0 is programmed
  localparam logic LOCK_UNPROG = 1'h1;
  localparam logic LOCK_PROG   = 1'h0;

  typedef enum logic [1:0] {
    OP_ERASE,
    OP_WRITE,
    OP_OTHER
  } pstore_op_t;

  typedef struct packed {
    logic              valid;
    pstore_op_t        op;
    logic [ADDR_W-1:0] target;
  } pstore_req_t;

  typedef struct packed {
    logic boot_lock_high_bit;
    logic boot_lock_low_bit;
    logic app_lock_high_bit;
    logic app_lock_low_bit;
  } lock_bits_t;

  localparam lock_bits_t LOCK_RESET = '{LOCK_UNPROG, LOCK_UNPROG, LOCK_UNPROG, LOCK_UNPROG};

  typedef struct packed {
    logic              start;
    pstore_op_t        op;
    logic [PAGE_W-1:0] page;
  } flash_cmd_t;

endpackage : flash_spm_pkg

// file: flash_self_program_rww_control.sv
// Flash self-programming gate with read-while-write section control
//
// Behaviour
// R1: Store instruction from application section ignored
// R2: Program only when fetched from boot loader
// R3: Boot loader may target any page
// R4: Concurrent section op keeps halting section readable
// R5: Halting section op stalls CPU throughout
// R6: Fixed concurrent/halting split, independent of fuses
// R7: Stall decided by target page section
// R8: Boot loader always inside halting section
// R9: Busy flag reads one while section blocked
// R10: Software clears busy flag before reading section
// R11: Software never reads section while programming
// R12: Software disables or relocates interrupts meanwhile
// R13: Boot size fuses set section boundary
// R14: Lock set 0 protects application section
// R15: Lock set 1 protects boot loader section
// R16: Page grouping used only for erase/write
// R17: Locks only programmed; chip erase restores
// R18: Lock set 1,0 blocks application writes
// R19: Busy flag set at start, software clears
`timescale 1ns/1ps
module flash_self_program_rww_control
  import flash_spm_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  input  wire pstore_req_t       i_pstore_req,
  input  wire logic [ADDR_W-1:0] i_fetch_addr,
  input  wire logic [1:0]        i_boot_size_fuses,
  input  wire logic              i_flash_done,
  input  wire logic              i_busy_clear,
  input  wire logic              i_lock_wr,
  input  wire lock_bits_t        i_lock_wr_data,
  input  wire logic              i_chip_erase,
  input  wire logic              i_pmem_read,
  input  wire logic [ADDR_W-1:0] i_pmem_read_addr,
  output flash_cmd_t             o_flash_cmd,
  output logic                   o_cpu_stall,
  output logic                   o_concurrent_section_busy_flag,
  output logic                   o_pstore_ignored,
  output logic                   o_pmem_read_deny,
  output lock_bits_t             o_lock_bits
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY_CONCURRENT,
    ST_BUSY_HALT
  } state_t;

  state_t      state_q, state_d;
  flash_cmd_t  cmd_q, cmd_d;
  logic        busy_q, busy_d;
  logic        ignored_q;
  lock_bits_t  lock_q, lock_d;

  function automatic logic [ADDR_W-1:0] boot_base(input logic [1:0] fuses);
    unique case (fuses)
      FUSE_SZ0: boot_base = BOOT_START_SZ0;
      FUSE_SZ1: boot_base = BOOT_START_SZ1;
      FUSE_SZ2: boot_base = BOOT_START_SZ2;
      default:  boot_base = BOOT_START_SZ3;
    endcase
  endfunction : boot_base

  function automatic logic in_concurrent(input logic [ADDR_W-1:0] addr);
    in_concurrent = (addr < HALT_SECTION_START);
  endfunction : in_concurrent

  // Section decoding
  wire logic [ADDR_W-1:0] boot_start  = boot_base(i_boot_size_fuses);       // R8 R13
  wire logic fetch_in_boot            = (i_fetch_addr >= boot_start);       // R2
  wire logic target_in_boot           = (i_pstore_req.target >= boot_start); // R3
  wire logic target_concurrent        = in_concurrent(i_pstore_req.target); // R6 R7
  wire logic read_in_boot             = (i_pmem_read_addr >= boot_start);

  // Lock decoding per section
  wire logic app_write_locked  = (lock_q.app_lock_low_bit == LOCK_PROG);   // R14 R18
  wire logic boot_write_locked = (lock_q.boot_lock_low_bit == LOCK_PROG);  // R15
  wire logic app_read_locked   = (lock_q.app_lock_high_bit == LOCK_PROG);  // R14
  wire logic boot_read_locked  = (lock_q.boot_lock_high_bit == LOCK_PROG); // R15
  wire logic target_locked     = target_in_boot ? boot_write_locked : app_write_locked;

  wire logic is_prog_op = (i_pstore_req.op == OP_ERASE) || (i_pstore_req.op == OP_WRITE);
  wire logic store_seen = i_pstore_req.valid && is_prog_op;

  // Only boot-resident code may start an operation; any target page outside a write-locked section is fine
  wire logic accept = store_seen && fetch_in_boot && !target_locked  // R1 R2 R3
                      && (state_q == ST_IDLE);

  always_comb begin
    state_d = state_q;
    cmd_d   = cmd_q;
    cmd_d.start = 1'b0;
    if (accept) begin
      cmd_d.start = 1'b1;
      cmd_d.op    = i_pstore_req.op;
      cmd_d.page  = i_pstore_req.target[ADDR_W-1:PAGE_BITS]; // R16
      state_d = target_concurrent ? ST_BUSY_CONCURRENT : ST_BUSY_HALT; // R7
    end else if (i_flash_done && (state_q != ST_IDLE)) begin
      state_d = ST_IDLE;
    end
  end

  // Set on a start wins over a software clear in the same cycle
  always_comb begin
    busy_d = busy_q;
    if (i_busy_clear && (state_q == ST_IDLE))
      busy_d = 1'b0; // R10
    if (accept && target_concurrent)
      busy_d = 1'b1; // R19
  end

  // Locks may only move towards programmed; chip erase or reset restores them
  always_comb begin
    lock_d = lock_q;
    if (i_lock_wr)
      lock_d = lock_bits_t'(lock_q & i_lock_wr_data); // R17
    if (i_chip_erase)
      lock_d = LOCK_RESET; // R17
  end

  wire logic ignored_d = store_seen && !accept; // R1

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmd_q <= '{1'b0, OP_OTHER, '0};
    end else begin
      cmd_q <= cmd_d;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ignored_q <= 1'b0;
    end else begin
      ignored_q <= ignored_d; // R1
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_q <= LOCK_RESET;
    end else begin
      lock_q <= lock_d;
    end
  end

  // Stall only for halting-section pages; concurrent ops leave the CPU running
  assign o_cpu_stall = (state_q == ST_BUSY_HALT); // R4 R5
  assign o_concurrent_section_busy_flag = busy_q;  // R9
  assign o_flash_cmd      = cmd_q;
  assign o_pstore_ignored = ignored_q;
  assign o_lock_bits      = lock_q;

  // Cross-section program reads gated by the high lock bits; reading the busy
  // concurrent section is left to software since the array returns garbage then
  assign o_pmem_read_deny = i_pmem_read && (
    (fetch_in_boot && !read_in_boot && app_read_locked) ||
    (!fetch_in_boot && read_in_boot && boot_read_locked)); // R14 R15

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  a_app_store_ignored: assert property ( // R1
    (store_seen && !fetch_in_boot) |=> (!o_flash_cmd.start && o_pstore_ignored))
    else $error("store from application section started an operation");

  a_boot_store_starts: assert property ( // R2
    (store_seen && fetch_in_boot && !target_locked && state_q == ST_IDLE)
      |=> (o_flash_cmd.start && o_flash_cmd.op == $past(i_pstore_req.op)))
    else $error("boot loader store did not start operation");

  a_boot_self_target: assert property ( // R3
    (accept && target_in_boot)
      |=> (o_flash_cmd.page == $past(i_pstore_req.target[ADDR_W-1:PAGE_BITS])))
    else $error("boot section page not passed to array");

  a_concurrent_no_stall: assert property ( // R4
    (accept && target_concurrent) |=> (!o_cpu_stall throughout (state_q != ST_IDLE)))
    else $error("CPU stalled for concurrent section operation");

  a_halt_stall_held: assert property ( // R5
    ((accept && !target_concurrent) || (o_cpu_stall && !i_flash_done))
      |=> o_cpu_stall)
    else $error("stall dropped before halting operation ended");

  a_stall_by_target: assert property ( // R7
    o_flash_cmd.start |-> (o_cpu_stall == !in_concurrent({o_flash_cmd.page, {PAGE_BITS{1'b0}}})))
    else $error("stall decision not tied to target section");

  a_boot_in_halt: assert property ( // R8
    boot_start >= HALT_SECTION_START)
    else $error("boot loader section overlaps concurrent section");

  a_busy_while_blocked: assert property ( // R9
    (state_q == ST_BUSY_CONCURRENT) |-> o_concurrent_section_busy_flag)
    else $error("busy flag low while concurrent section blocked");

  a_busy_sticky: assert property ( // R19
    (o_concurrent_section_busy_flag && !i_busy_clear) |=> o_concurrent_section_busy_flag)
    else $error("busy flag fell without software clear");

  a_app_lock_write: assert property ( // R18
    (store_seen && !target_in_boot && lock_q.app_lock_high_bit == LOCK_UNPROG
      && lock_q.app_lock_low_bit == LOCK_PROG) |=> !o_flash_cmd.start)
    else $error("write to locked application section started");

  a_lock_one_way: assert property ( // R17
    (lock_q.app_lock_low_bit == LOCK_PROG && !i_chip_erase)
      |=> (lock_q.app_lock_low_bit == LOCK_PROG))
    else $error("lock bit restored without chip erase");

  a_start_one_cycle: assert property ( // R2
    o_flash_cmd.start
      |=> !o_flash_cmd.start)
    else $error("operation start held for more than one cycle");

  a_start_from_boot: assert property ( // R1 R2
    o_flash_cmd.start
      |-> $past(store_seen && fetch_in_boot))
    else $error("operation started without a boot loader store");

  a_refuse_while_busy: assert property ( // R2
    (store_seen && state_q != ST_IDLE)
      |=> (o_pstore_ignored && !o_flash_cmd.start))
    else $error("store accepted while an operation was running");

  a_ignored_cause: assert property ( // R1
    o_pstore_ignored
      |-> $past(store_seen))
    else $error("ignored flag raised without a store");

  a_busy_on_start: assert property ( // R19
    (accept && target_concurrent)
      |=> o_concurrent_section_busy_flag)
    else $error("busy flag not set by concurrent section start");

  a_busy_clear_idle: assert property ( // R19
    (o_concurrent_section_busy_flag && i_busy_clear && state_q == ST_IDLE
      && !(accept && target_concurrent)) |=> !o_concurrent_section_busy_flag)
    else $error("software clear of busy flag not honoured");

  a_halt_read_open: assert property ( // R4
    (state_q == ST_BUSY_CONCURRENT && i_pmem_read && fetch_in_boot && read_in_boot)
      |-> !o_pmem_read_deny)
    else $error("halting section read refused during concurrent operation");

  a_stall_released: assert property ( // R5
    (o_cpu_stall && i_flash_done)
      |=> !o_cpu_stall)
    else $error("stall held after halting operation ended");

  a_boot_lock_write: assert property ( // R15
    (store_seen && target_in_boot && lock_q.boot_lock_low_bit == LOCK_PROG)
      |=> !o_flash_cmd.start)
    else $error("write to locked boot loader section started");

  a_lock_erase: assert property ( // R17
    i_chip_erase
      |=> (o_lock_bits == LOCK_RESET))
    else $error("chip erase did not restore lock bits");

  a_lock_no_release: assert property ( // R17
    !i_chip_erase
      |=> ((o_lock_bits & ~$past(o_lock_bits)) == '0))
    else $error("lock bit returned to unprogrammed without chip erase");

  a_app_read_deny: assert property ( // R14
    (i_pmem_read && fetch_in_boot && !read_in_boot && app_read_locked)
      |-> o_pmem_read_deny)
    else $error("locked application section read not refused");

  a_boot_read_deny: assert property ( // R15
    (i_pmem_read && !fetch_in_boot && read_in_boot && boot_read_locked)
      |-> o_pmem_read_deny)
    else $error("locked boot loader section read not refused");

  a_page_held: assert property ( // R16
    !o_flash_cmd.start
      |-> $stable(o_flash_cmd.page))
    else $error("page changed without an operation start");

  c_concurrent_op: cover property (accept && target_concurrent ##[1:20] i_flash_done);
  c_halt_op:       cover property (accept && !target_concurrent ##[1:20] i_flash_done);
  c_app_ignored:   cover property (store_seen && !fetch_in_boot);
  c_busy_cleared:  cover property (o_concurrent_section_busy_flag ##1 !o_concurrent_section_busy_flag);
  c_read_denied:   cover property (o_pmem_read_deny);

endmodule : flash_self_program_rww_control

// file: flash_self_program_rww_control_tb.sv
// Self-checking testbench for the flash self-programming gate
`timescale 1ns/1ps
module flash_self_program_rww_control_tb;
  import flash_spm_pkg::*;
  logic              i_ref_clk = 1'b0;
  logic              i_nrst = 1'b0;
  pstore_req_t       i_pstore_req = '0;
  logic [ADDR_W-1:0] i_fetch_addr = '0;
  logic [1:0]        i_boot_size_fuses = 2'h0;
  logic              i_flash_done = 1'b0;
  logic              i_busy_clear = 1'b0;
  logic              i_lock_wr = 1'b0;
  lock_bits_t        i_lock_wr_data = '1;
  logic              i_chip_erase = 1'b0;
  logic              i_pmem_read = 1'b0;
  logic [ADDR_W-1:0] i_pmem_read_addr = '0;
  flash_cmd_t        o_flash_cmd;
  logic              o_cpu_stall, o_concurrent_section_busy_flag, o_pstore_ignored;
  logic              o_pmem_read_deny;
  lock_bits_t        o_lock_bits;
  int                bad_count = 0;
  int                n_checks = 0;

  always #10 i_ref_clk = ~i_ref_clk;

  flash_self_program_rww_control dut_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_pstore_req(i_pstore_req), .i_fetch_addr(i_fetch_addr),
    .i_boot_size_fuses(i_boot_size_fuses), .i_flash_done(i_flash_done),
    .i_busy_clear(i_busy_clear), .i_lock_wr(i_lock_wr), .i_lock_wr_data(i_lock_wr_data),
    .i_chip_erase(i_chip_erase), .i_pmem_read(i_pmem_read),
    .i_pmem_read_addr(i_pmem_read_addr), .o_flash_cmd(o_flash_cmd), .o_cpu_stall(o_cpu_stall),
    .o_concurrent_section_busy_flag(o_concurrent_section_busy_flag),
    .o_pstore_ignored(o_pstore_ignored), .o_pmem_read_deny(o_pmem_read_deny),
    .o_lock_bits(o_lock_bits));

  // Inputs always move 1 ns after the edge, so sampling never races the drive
  task automatic tick();
    @(posedge i_ref_clk);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle store request; returns just after the sampling edge
  task automatic store(input logic [14:0] fetch, input logic [14:0] tgt, input pstore_op_t op);
    i_pstore_req = '{1'b1, op, tgt};
    i_fetch_addr = fetch;
    tick();
    i_pstore_req.valid = 1'b0;
  endtask : store

  // Array reports completion; the idle state lands on that edge, one spare cycle follows
  task automatic finish_op();
    i_flash_done = 1'b1;
    tick();
    i_flash_done = 1'b0;
    tick();
  endtask : finish_op

  task automatic clear_busy();
    i_busy_clear = 1'b1;
    tick();
    i_busy_clear = 1'b0;
  endtask : clear_busy

  task automatic t_app_ignored();
    store(15'h0100, 15'h0200, OP_WRITE);
    chk("ignored", 16'h1, o_pstore_ignored);
    chk("start", 16'h0, o_flash_cmd.start);
    tick();
    chk("ignored pulse", 16'h0, o_pstore_ignored);
  endtask : t_app_ignored

  task automatic t_concurrent();
    store(15'h7e10, 15'h0100, OP_WRITE);
    chk("start", 16'h1, o_flash_cmd.start);
    chk("page", 16'h02, o_flash_cmd.page);
    chk("busy", 16'h1, o_concurrent_section_busy_flag);
    chk("stall", 16'h0, o_cpu_stall);
    i_pmem_read = 1'b1;
    i_pmem_read_addr = 15'h7100;
    tick();
    chk("halt read deny", 16'h0, o_pmem_read_deny);
    chk("start pulse", 16'h0, o_flash_cmd.start);
    i_pmem_read = 1'b0;
    store(15'h7e10, 15'h0300, OP_ERASE);
    chk("busy refuse", 16'h1, o_pstore_ignored);
    clear_busy();
    chk("clear while busy", 16'h1, o_concurrent_section_busy_flag);
    finish_op();
    chk("busy sticky", 16'h1, o_concurrent_section_busy_flag);
    clear_busy();
    chk("busy clear", 16'h0, o_concurrent_section_busy_flag);
  endtask : t_concurrent

  task automatic t_halting();
    store(15'h7e10, 15'h7e20, OP_ERASE);
    chk("start", 16'h1, o_flash_cmd.start);
    chk("page", 16'hfc, o_flash_cmd.page);
    chk("busy", 16'h0, o_concurrent_section_busy_flag);
    repeat (3) begin
      chk("stall held", 16'h1, o_cpu_stall);
      tick();
    end
    finish_op();
    chk("stall end", 16'h0, o_cpu_stall);
  endtask : t_halting

  // Each fuse code: one below the boot start is refused, the start itself is taken
  task automatic t_fuses();
    logic [14:0] starts [4];
    starts = '{15'h7000, 15'h7800, 15'h7c00, 15'h7e00};
    for (int k = 0; k < 4; k++) begin
      i_boot_size_fuses = 2'(k);
      store(starts[k] - 15'h1, 15'h7100, OP_WRITE);
      chk("below boot", 16'h1, o_pstore_ignored);
      tick();
      store(starts[k], 15'h7100, OP_WRITE);
      chk("boot start", 16'h1, o_flash_cmd.start);
      chk("fixed split", 16'h1, o_cpu_stall);
      finish_op();
    end
    store(15'h7e10, 15'h0100, OP_OTHER);
    chk("other op", 16'h0, {o_flash_cmd.start, o_pstore_ignored});
  endtask : t_fuses

  task automatic lock_op(input logic wr, input logic er, input lock_bits_t d);
    i_lock_wr = wr;
    i_chip_erase = er;
    i_lock_wr_data = d;
    tick();
    i_lock_wr = 1'b0;
    i_chip_erase = 1'b0;
  endtask : lock_op

  task automatic t_locks();
    lock_op(1'b1, 1'b0, 4'he);
    chk("app lock", 16'he, o_lock_bits);
    store(15'h7e10, 15'h0100, OP_WRITE);
    chk("app locked", 16'h1, o_pstore_ignored);
    lock_op(1'b1, 1'b0, 4'hf);
    chk("no unprogram", 16'he, o_lock_bits);
    lock_op(1'b1, 1'b0, 4'hb);
    store(15'h7e10, 15'h7e20, OP_WRITE);
    chk("boot locked", 16'h1, o_pstore_ignored);
    lock_op(1'b1, 1'b0, 4'h5);
    chk("all locks", 16'h0, o_lock_bits);
    i_pmem_read = 1'b1;
    i_pmem_read_addr = 15'h0100;
    tick();
    chk("app read deny", 16'h1, o_pmem_read_deny);
    i_fetch_addr = 15'h0100;
    i_pmem_read_addr = 15'h7e20;
    tick();
    chk("boot read deny", 16'h1, o_pmem_read_deny);
    i_pmem_read = 1'b0;
    lock_op(1'b1, 1'b1, 4'h0);
    chk("chip erase", 16'hf, o_lock_bits);
  endtask : t_locks

  // Reset in the middle of a halting operation must drop stall and restore locks
  task automatic t_reset_mid();
    lock_op(1'b1, 1'b0, 4'he);
    store(15'h7e10, 15'h7e20, OP_WRITE);
    chk("stall before reset", 16'h1, o_cpu_stall);
    i_nrst = 1'b0;
    tick();
    chk("reset stall", 16'h0, o_cpu_stall);
    chk("reset start", 16'h0, o_flash_cmd.start);
    chk("reset lock bits", 16'hf, o_lock_bits);
    i_nrst = 1'b1;
    store(15'h7e10, 15'h0100, OP_WRITE);
    chk("start after reset", 16'h1, o_flash_cmd.start);
    chk("busy after reset", 16'h1, o_concurrent_section_busy_flag);
    finish_op();
    clear_busy();
    chk("busy clear after reset", 16'h0, o_concurrent_section_busy_flag);
  endtask : t_reset_mid

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Whole run is about 57 cycles; 200 us is ample margin
  initial begin
    #200us;
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge i_ref_clk);
    chk("reset locks", 16'hf, o_lock_bits);
    #1;
    i_nrst = 1'b1;
    t_app_ignored();
    t_concurrent();
    t_halting();
    t_fuses();
    t_locks();
    t_reset_mid();
    complete_run();
  end
endmodule : flash_self_program_rww_control_tb
